/* operand_addressing_constgen.sv */
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
// Operation
// RULE_01: Status slot with mode 10 or 11 yields +4 or +8, no fetch.
// RULE_02: Constant register three with modes 00,01,10 yields 0, +1, +2.
// RULE_03: Constant register three mode 11 yields all-ones of operation width.
// RULE_04: Generated constants use no code word and no fetch cycle.
// RULE_05: Constant registers are source-only in constant mode, never written.
// RULE_06: Status slot mode 01 is absolute: index word plus zero base.
// RULE_07: Byte write stores low 8 bits, clears bits 19:8.
// RULE_08: Word write stores low 16 bits, clears bits 19:16.
// RULE_09: Sign extend copies bit 7 into bits 19:8.
// RULE_10: Byte register reads take low 8 bits, source unchanged.
// RULE_11: Word register ops read and write low 16 bits.
// RULE_12: Address-word register ops move all 20 bits, source unchanged.
// RULE_13: Source mode 00..11 and destination bit 0/1 select modes.
// RULE_14: Indexed address is register plus index, upper bits from extension.
// RULE_15: Symbolic mode is indexed on the program counter.
// RULE_16: Indirect uses register as address, register unchanged.
// RULE_17: Autoincrement adds 1, 2 or 4 by operation width.
// RULE_18: Immediate is autoincrement on program counter, skipping the word.
// RULE_19: Length bit and byte/word bit equal 01 select 20-bit data.
// RULE_20: Status slot mode 00 reads the ordinary status register.
module operand_addressing_constgen
  import opaddr_pkg::*;
(
  input  wire logic        clock,       // Core clock
  input  wire logic        rst_b,       // Async reset, active low
  input  wire logic        dec_valid,   // Instruction decode strobe
  input  wire logic [3:0]  src_reg,     // Source register number
  input  wire logic [1:0]  src_mode,    // src_mode_field
  input  wire logic [3:0]  dst_reg,     // Destination register number
  input  wire logic        dst_mode,    // Destination mode bit
  input  wire logic        len_bit,     // Extension length bit
  input  wire logic        bw_bit,      // Byte/word bit
  input  wire logic        ext_valid,   // Extension word present
  input  wire logic [3:0]  ext_src_hi,  // Source index bits 19:16
  input  wire logic [3:0]  ext_dst_hi,  // Destination index bits 19:16
  input  wire logic [15:0] src_index,   // Source index word
  input  wire logic [15:0] dst_index,   // Destination index word
  input  wire logic        wr_en,       // Result write to register
  input  wire logic [19:0] wr_data,     // Result value
  input  wire logic        sign_extend_op, // Sign extend on result write
  output logic [19:0]      src_operand_r,  // Register or constant operand
  output logic [1:0]       src_kind_r,     // opnd_kind_t of source
  output logic [19:0]      src_addr_r,     // Source memory address
  output logic [19:0]      dst_addr_r,     // Destination memory address
  output logic             dst_is_mem_r,   // Destination is memory
  output logic [1:0]       src_words_r,    // Extra code words for source
  output logic             fetch_req_r,    // Source needs code fetch
  output logic [1:0]       width_r,        // len_bw_t of operation
  output logic [19:0]      reg_view_r [NREG] // Register file contents
);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [19:0]     regs_r [NREG];
  logic [19:0]     wr_val_nxt;
  logic [19:0]     inc_step;
  logic [19:0]     auto_step;
  logic            cgen_src;
  logic            auto_inc;
  logic [19:0]     const_val;
  logic [19:0]     src_idx20;
  logic [19:0]     dst_idx20;
  logic [19:0]     src_base;
  logic            dst_const;
  len_bw_t         width;

  assign width = len_bw_t'({len_bit, bw_bit}); // RULE_19

  // Autoincrement step by operation width
  always_comb begin
    case (width)
      OW_BYTE: inc_step = INC_B;  // RULE_17
      OW_A20:  inc_step = INC_A;  // RULE_17
      default: inc_step = INC_W;  // RULE_17
    endcase
  end

  // PC steps a whole code word past an immediate, even for bytes
  assign auto_step = (src_reg == REG_PC) ? INC_W : inc_step; // RULE_18

  // Constant generator decode; never reaches the fetch unit
  always_comb begin
    cgen_src  = 1'b0;
    const_val = K_0;
    if (src_reg == REG_SR) begin
      case (src_mode)
        SM_IND: begin
          cgen_src  = 1'b1;
          const_val = K_P4;  // RULE_01
        end
        SM_AUTO: begin
          cgen_src  = 1'b1;
          const_val = K_P8;  // RULE_01
        end
        default: cgen_src = 1'b0; // RULE_20
      endcase
    end else if (src_reg == REG_CG3) begin
      cgen_src = 1'b1;
      case (src_mode)
        SM_REG:  const_val = K_0;   // RULE_02
        SM_IDX:  const_val = K_P1;  // RULE_02
        SM_IND:  const_val = K_P2;  // RULE_02
        default: begin
          case (width)
            OW_BYTE: const_val = K_M1_B; // RULE_03
            OW_A20:  const_val = K_M1_A; // RULE_03
            default: const_val = K_M1_W; // RULE_03
          endcase
        end
      endcase
    end
  end

  // Index words, upper bits from extension or sign extension
  assign src_idx20 = ext_valid ? {ext_src_hi, src_index}                 // RULE_14
                               : {{4{src_index[WORD_HI]}}, src_index};
  assign dst_idx20 = ext_valid ? {ext_dst_hi, dst_index}                 // RULE_14
                               : {{4{dst_index[WORD_HI]}}, dst_index};
  // Absolute mode uses a zero base on the status slot
  assign src_base  = (src_reg == REG_SR) ? ZERO20 : regs_r[src_reg];    // RULE_06
  assign auto_inc  = dec_valid && (src_mode == SM_AUTO) && !cgen_src;
  // Constant registers as destination are discarded
  assign dst_const = (dst_reg == REG_SR && dst_mode) || (dst_reg == REG_CG3); // RULE_05

  // Value written to a working register by width
  always_comb begin
    if (sign_extend_op) begin
      wr_val_nxt = {{12{wr_data[SIGN_B]}}, wr_data[BYTE_HI:0]};  // RULE_09
    end else begin
      case (width)
        OW_BYTE: wr_val_nxt = {12'h000, wr_data[BYTE_HI:0]};     // RULE_07
        OW_A20:  wr_val_nxt = wr_data;                            // RULE_12
        default: wr_val_nxt = {4'h0, wr_data[WORD_HI:0]};         // RULE_08 RULE_11
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register update: result write and autoincrement
  // ----------------------------------------------------------------
  // Autoincrement wins over a result write to the same register so a pointer step is not lost
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_reg
      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          regs_r[gi] <= ZERO20;
        end else if (gi == REG_CG3) begin
          regs_r[gi] <= ZERO20;                                   // RULE_05
        end else if (auto_inc && src_reg == gi) begin
          regs_r[gi] <= regs_r[gi] + auto_step;                   // RULE_17 RULE_18
        end else if (wr_en && !dst_mode && dst_reg == gi && !dst_const) begin
          regs_r[gi] <= wr_val_nxt;
        end
      end
      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          reg_view_r[gi] <= ZERO20;
        end else begin
          reg_view_r[gi] <= regs_r[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Operand decode outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      src_operand_r <= ZERO20;
      src_kind_r    <= OK_REG;
      src_addr_r    <= ZERO20;
      src_words_r   <= 2'h0;
      fetch_req_r   <= 1'b0;
      width_r       <= OW_WORD;
    end else if (dec_valid) begin
      width_r <= width;
      if (cgen_src) begin
        src_operand_r <= const_val;  // RULE_01 RULE_02 RULE_03
        src_kind_r    <= OK_CONST;
        src_addr_r    <= ZERO20;
        src_words_r   <= 2'h0;       // RULE_04
        fetch_req_r   <= 1'b0;       // RULE_04
      end else begin
        case (src_mode)
          SM_REG: begin            // RULE_13
            case (width)
              OW_BYTE: src_operand_r <= {12'h000, regs_r[src_reg][BYTE_HI:0]}; // RULE_10
              OW_A20:  src_operand_r <= regs_r[src_reg];                        // RULE_12
              default: src_operand_r <= {4'h0, regs_r[src_reg][WORD_HI:0]};    // RULE_11
            endcase
            src_kind_r  <= OK_REG;
            src_addr_r  <= ZERO20;
            src_words_r <= 2'h0;
            fetch_req_r <= 1'b0;
          end
          SM_IDX: begin            // RULE_13
            // Program counter as base gives symbolic mode
            src_operand_r <= ZERO20;
            src_kind_r    <= OK_MEM;
            src_addr_r    <= src_base + src_idx20;  // RULE_14 RULE_15 RULE_06
            src_words_r   <= 2'h1;
            fetch_req_r   <= 1'b1;
          end
          SM_IND: begin
            src_operand_r <= ZERO20;
            src_kind_r    <= OK_MEM;
            src_addr_r    <= regs_r[src_reg];       // RULE_16
            src_words_r   <= 2'h0;
            fetch_req_r   <= 1'b0;
          end
          default: begin
            // Immediate on PC fetches the next word via the pointer
            src_operand_r <= ZERO20;
            src_kind_r    <= OK_MEM;
            src_addr_r    <= regs_r[src_reg];       // RULE_18
            src_words_r   <= (src_reg == REG_PC) ? 2'h1 : 2'h0;
            fetch_req_r   <= (src_reg == REG_PC);
          end
        endcase
      end
    end
  end

  // Destination address, register or indexed
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dst_addr_r   <= ZERO20;
      dst_is_mem_r <= 1'b0;
    end else if (dec_valid) begin
      dst_is_mem_r <= dst_mode;                                           // RULE_13
      dst_addr_r   <= dst_mode ? (((dst_reg == REG_SR) ? ZERO20 : regs_r[dst_reg])
                                  + dst_idx20) : ZERO20;                  // RULE_14
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Constant generator and constant registers
  a_cg_plus_four: assert property ( // RULE_01
    @(posedge clock) disable iff (!rst_b)
    dec_valid && src_reg == REG_SR && src_mode == SM_IND
    |=> src_operand_r == K_P4 && !fetch_req_r)
    else $error("status slot mode 10 not +4");
  a_cg_plus_eight: assert property ( // RULE_01
    @(posedge clock) disable iff (!rst_b)
    dec_valid && src_reg == REG_SR && src_mode == SM_AUTO
    |=> src_operand_r == K_P8 && src_kind_r == OK_CONST)
    else $error("status slot mode 11 not +8");
  a_cg_zero: assert property ( // RULE_02
    @(posedge clock) disable iff (!rst_b)
    dec_valid && src_reg == REG_CG3 && src_mode == SM_REG
    |=> src_operand_r == K_0 && src_kind_r == OK_CONST)
    else $error("const reg mode 00 not 0");
  a_cg_small_const: assert property ( // RULE_02
    @(posedge clock) disable iff (!rst_b)
    dec_valid && src_reg == REG_CG3 && src_mode == SM_IDX
    |=> src_operand_r == K_P1)
    else $error("const reg mode 01 not +1");
  a_cg_plus_two: assert property ( // RULE_02
    @(posedge clock) disable iff (!rst_b)
    dec_valid && src_reg == REG_CG3 && src_mode == SM_IND
    |=> src_operand_r == K_P2)
    else $error("const reg mode 10 not +2");
  a_cg_all_ones: assert property ( // RULE_03
    @(posedge clock) disable iff (!rst_b)
    dec_valid && src_reg == REG_CG3 && src_mode == SM_AUTO && {len_bit, bw_bit} == 2'b11
    |=> src_operand_r == K_M1_B)
    else $error("byte minus one wrong");
  a_ones_word: assert property ( // RULE_03
    @(posedge clock) disable iff (!rst_b)
    dec_valid && src_reg == REG_CG3 && src_mode == SM_AUTO && {len_bit, bw_bit} == 2'b10
    |=> src_operand_r == K_M1_W)
    else $error("word minus one wrong");
  a_ones_addr: assert property ( // RULE_03
    @(posedge clock) disable iff (!rst_b)
    dec_valid && src_reg == REG_CG3 && src_mode == SM_AUTO && {len_bit, bw_bit} == 2'b01
    |=> src_operand_r == K_M1_A)
    else $error("address-word minus one wrong");
  a_cg_no_fetch: assert property ( // RULE_04
    @(posedge clock) disable iff (!rst_b)
    src_kind_r == OK_CONST
    |-> src_words_r == 2'h0 && !fetch_req_r)
    else $error("constant consumed a word");
  a_cg_no_step: assert property ( // RULE_04
    @(posedge clock) disable iff (!rst_b)
    dec_valid && src_reg == REG_SR && src_mode == SM_AUTO && !wr_en
    |=> regs_r[REG_SR] == $past(regs_r[REG_SR]))
    else $error("constant mode stepped status slot");
  a_cg3_const: assert property ( // RULE_05
    @(posedge clock) disable iff (!rst_b)
    wr_en && dst_reg == REG_CG3
    |=> regs_r[REG_CG3] == ZERO20)
    else $error("constant register written");
  a_abs_zero: assert property ( // RULE_06
    @(posedge clock) disable iff (!rst_b)
    dec_valid && src_reg == REG_SR && src_mode == SM_IDX
    |=> src_addr_r == $past(src_idx20))
    else $error("absolute address wrong");

  // Register writes and register-mode reads
  a_byte_clear: assert property ( // RULE_07
    @(posedge clock) disable iff (!rst_b)
    wr_en && !dst_mode && dst_reg == 4'h5 && !auto_inc && !sign_extend_op
    && {len_bit, bw_bit} == 2'b11 |=> regs_r[5][19:8] == 12'h000)
    else $error("byte write kept upper bits");
  a_word_clear: assert property ( // RULE_08
    @(posedge clock) disable iff (!rst_b)
    wr_en && !dst_mode && dst_reg == 4'h5 && !auto_inc && !sign_extend_op
    && {len_bit, bw_bit} == 2'b10 |=> regs_r[5] == {4'h0, $past(wr_data[WORD_HI:0])})
    else $error("word write kept upper bits");
  a_sign_ext: assert property ( // RULE_09
    @(posedge clock) disable iff (!rst_b)
    wr_en && !dst_mode && dst_reg == 4'h5 && !auto_inc && sign_extend_op
    |=> regs_r[5] == {{12{$past(wr_data[7])}}, $past(wr_data[7:0])})
    else $error("sign extension wrong");
  a_byte_read: assert property ( // RULE_10
    @(posedge clock) disable iff (!rst_b)
    dec_valid && src_mode == SM_REG && src_reg == 4'h7 && {len_bit, bw_bit} == 2'b11
    |=> src_operand_r == {12'h000, $past(regs_r[7][BYTE_HI:0])})
    else $error("byte read wrong");
  a_word_read: assert property ( // RULE_11
    @(posedge clock) disable iff (!rst_b)
    dec_valid && src_mode == SM_REG && src_reg == 4'h7 && {len_bit, bw_bit} == 2'b10
    |=> src_operand_r == {4'h0, $past(regs_r[7][WORD_HI:0])})
    else $error("word read wrong");
  a_addr_read: assert property ( // RULE_12
    @(posedge clock) disable iff (!rst_b)
    dec_valid && src_mode == SM_REG && src_reg == 4'h7 && {len_bit, bw_bit} == 2'b01
    |=> src_operand_r == $past(regs_r[7]))
    else $error("address-word read wrong");
  a_status_read: assert property ( // RULE_20
    @(posedge clock) disable iff (!rst_b)
    dec_valid && src_reg == REG_SR && src_mode == SM_REG && {len_bit, bw_bit} == 2'b10
    |=> src_operand_r == {4'h0, $past(regs_r[REG_SR][WORD_HI:0])})
    else $error("status register read wrong");

  // Addressing modes and pointer steps
  a_reg_kind: assert property ( // RULE_13
    @(posedge clock) disable iff (!rst_b)
    dec_valid && src_mode == SM_REG && src_reg != REG_CG3
    |=> src_kind_r == OK_REG)
    else $error("register mode kind wrong");
  a_dst_mode: assert property ( // RULE_13
    @(posedge clock) disable iff (!rst_b)
    dec_valid
    |=> dst_is_mem_r == $past(dst_mode))
    else $error("destination mode wrong");
  a_index_ext: assert property ( // RULE_14
    @(posedge clock) disable iff (!rst_b)
    dec_valid && src_mode == SM_IDX && src_reg == 4'h6 && ext_valid
    |=> src_addr_r == $past(regs_r[6]) + $past({ext_src_hi, src_index}))
    else $error("indexed source address wrong");
  a_dst_index: assert property ( // RULE_14
    @(posedge clock) disable iff (!rst_b)
    dec_valid && dst_mode && dst_reg == 4'h6 && ext_valid
    |=> dst_addr_r == $past(regs_r[6]) + $past({ext_dst_hi, dst_index}))
    else $error("indexed destination address wrong");
  a_symbolic: assert property ( // RULE_15
    @(posedge clock) disable iff (!rst_b)
    dec_valid && src_mode == SM_IDX && src_reg == REG_PC
    |=> src_addr_r == $past(regs_r[REG_PC]) + $past(src_idx20))
    else $error("symbolic address wrong");
  a_indirect_keep: assert property ( // RULE_16
    @(posedge clock) disable iff (!rst_b)
    dec_valid && src_mode == SM_IND && src_reg == 4'h6 && !(wr_en && dst_reg == 4'h6)
    |=> regs_r[6] == $past(regs_r[6]) && src_addr_r == $past(regs_r[6]))
    else $error("indirect address wrong");
  a_auto_step: assert property ( // RULE_17
    @(posedge clock) disable iff (!rst_b)
    auto_inc && src_reg == 4'h6 && {len_bit, bw_bit} == 2'b01
    |=> regs_r[6] == $past(regs_r[6]) + INC_A)
    else $error("autoincrement step wrong");
  a_imm_step: assert property ( // RULE_18
    @(posedge clock) disable iff (!rst_b)
    dec_valid && src_reg == REG_PC && src_mode == SM_AUTO
    |=> regs_r[REG_PC] == $past(regs_r[REG_PC]) + INC_W && fetch_req_r)
    else $error("immediate step wrong");
  a_width_code: assert property ( // RULE_19
    @(posedge clock) disable iff (!rst_b)
    dec_valid && {len_bit, bw_bit} == 2'b01
    |=> width_r == OW_A20)
    else $error("20-bit width not decoded");

endmodule : operand_addressing_constgen

/* opaddr_pkg.sv */
package opaddr_pkg;
  // ----------------------------------------------------------------
  // Widths and register numbers
  // ----------------------------------------------------------------
  localparam int          DW          = 20;
  localparam int          NREG        = 16;
  localparam logic [3:0]  REG_PC      = 4'h0;
  localparam logic [3:0]  REG_SR      = 4'h2;  // status_reg_slot / const_gen_first
  localparam logic [3:0]  REG_CG3     = 4'h3;  // const_reg_three / const_gen_second
  localparam logic [19:0] ZERO20      = 20'h00000;

  // ----------------------------------------------------------------
  // Generated constants
  // ----------------------------------------------------------------
  localparam logic [19:0] K_P4        = 20'h00004;
  localparam logic [19:0] K_P8        = 20'h00008;
  localparam logic [19:0] K_0         = 20'h00000;
  localparam logic [19:0] K_P1        = 20'h00001;
  localparam logic [19:0] K_P2        = 20'h00002;
  localparam logic [19:0] K_M1_B      = 20'h000ff;
  localparam logic [19:0] K_M1_W      = 20'h0ffff;
  localparam logic [19:0] K_M1_A      = 20'hfffff;

  // ----------------------------------------------------------------
  // Autoincrement steps and field positions
  // ----------------------------------------------------------------
  localparam logic [19:0] INC_B       = 20'h00001;
  localparam logic [19:0] INC_W       = 20'h00002;
  localparam logic [19:0] INC_A       = 20'h00004;
  localparam int          SIGN_B      = 7;
  localparam int          BYTE_HI     = 7;
  localparam int          WORD_HI     = 15;

  // Source mode field encodings
  typedef enum logic [1:0] {
    SM_REG  = 2'b00,
    SM_IDX  = 2'b01,
    SM_IND  = 2'b10,
    SM_AUTO = 2'b11
  } src_mode_field_t;

  // Operation width from extension length bit and byte/word bit
  typedef enum logic [1:0] {
    OW_RSV  = 2'b00,
    OW_A20  = 2'b01,
    OW_WORD = 2'b10,
    OW_BYTE = 2'b11
  } len_bw_t;

  // Operand source kinds
  typedef enum logic [1:0] {
    OK_REG   = 2'b00,
    OK_CONST = 2'b01,
    OK_MEM   = 2'b10
  } opnd_kind_t;
endpackage : opaddr_pkg

/* fetch_unit_model.sv */
`timescale 1ns/1ns
// ------------------------------------------------------------
// Fetch unit stand-in: offers extension and index words
// ------------------------------------------------------------
module fetch_unit_model (
  input  wire logic        clock,       // Core clock
  input  wire logic        present,     // Words are on offer
  input  wire logic        ext_on,      // Extension word is part of the offer
  input  wire logic [39:0] words,       // Source hi, dest hi, source word, dest word
  output logic             ext_valid,   // Extension word present
  output logic [3:0]       ext_src_hi,  // Source index bits 19:16
  output logic [3:0]       ext_dst_hi,  // Destination index bits 19:16
  output logic [15:0]      src_index,   // Source index word
  output logic [15:0]      dst_index    // Destination index word
);
  logic [39:0] last_r = 40'h0;

  // Remember the last offer so released lines can be scrambled
  always_ff @(posedge clock) begin
    if (present) begin
      last_r <= words;
    end
  end

  // Released lines show the inverse, so a stale word never looks valid
  assign {ext_src_hi, ext_dst_hi, src_index, dst_index} = present ? words : ~last_r;
  assign ext_valid = present & ext_on;
endmodule : fetch_unit_model

/* tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  import opaddr_pkg::*;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic        dec_valid = 1'b0, dst_mode = 1'b0, len_bit = 1'b1, bw_bit = 1'b0;
  logic [3:0]  src_reg = 4'h4, dst_reg = 4'h4;
  logic [1:0]  src_mode = 2'h0;
  logic        wr_en = 1'b0, sign_extend_op = 1'b0, present = 1'b0, ext_on = 1'b0;
  logic [19:0] wr_data = 20'h0;
  logic [39:0] words = 40'h0;
  logic        ext_valid, dst_is_mem_r, fetch_req_r;
  logic [3:0]  ext_src_hi, ext_dst_hi;
  logic [15:0] src_index, dst_index;
  logic [19:0] src_operand_r, src_addr_r, dst_addr_r;
  logic [1:0]  src_kind_r, src_words_r, width_r;
  logic [19:0] regs [NREG];
  int          n_mismatch = 0;
  int          compares = 0;

  always #25 clock = ~clock;

  operand_addressing_constgen operand_addressing_constgen_inst (
    .clock(clock), .rst_b(rst_b), .dec_valid(dec_valid), .src_reg(src_reg),
    .src_mode(src_mode), .dst_reg(dst_reg), .dst_mode(dst_mode), .len_bit(len_bit),
    .bw_bit(bw_bit), .ext_valid(ext_valid), .ext_src_hi(ext_src_hi),
    .ext_dst_hi(ext_dst_hi), .src_index(src_index), .dst_index(dst_index),
    .wr_en(wr_en), .wr_data(wr_data), .sign_extend_op(sign_extend_op),
    .src_operand_r(src_operand_r), .src_kind_r(src_kind_r), .src_addr_r(src_addr_r),
    .dst_addr_r(dst_addr_r), .dst_is_mem_r(dst_is_mem_r), .src_words_r(src_words_r),
    .fetch_req_r(fetch_req_r), .width_r(width_r), .reg_view_r(regs));

  fetch_unit_model fetch_unit_model_inst (
    .clock(clock), .present(present), .ext_on(ext_on), .words(words),
    .ext_valid(ext_valid), .ext_src_hi(ext_src_hi), .ext_dst_hi(ext_dst_hi),
    .src_index(src_index), .dst_index(dst_index));

  // ----------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------
  task automatic conclude;
    if (n_mismatch == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [19:0] seen, input logic [19:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // One decode strobe; returns once the answer stands
  task automatic dec(input logic [3:0] sr, input logic [1:0] sm, input logic [3:0] dr,
                     input logic dm, input logic [1:0] lw);
    @(posedge clock);
    dec_valid <= 1'b1;
    src_reg   <= sr;
    src_mode  <= sm;
    dst_reg   <= dr;
    dst_mode  <= dm;
    {len_bit, bw_bit} <= lw;
    @(posedge clock);
    dec_valid <= 1'b0;
    @(posedge clock);
    #1;
  endtask : dec

  // Decode the width first so either width source agrees at the write
  task automatic wr(input logic [3:0] r, input logic [1:0] lw, input logic [19:0] d,
                    input logic sx);
    dec(r, SM_REG, r, 1'b0, lw);
    @(posedge clock);
    wr_en          <= 1'b1;
    wr_data        <= d;
    sign_extend_op <= sx;
    @(posedge clock);
    wr_en          <= 1'b0;
    sign_extend_op <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
  endtask : wr

  task automatic offer(input logic e, input logic [39:0] w);
    @(posedge clock);
    present <= 1'b1;
    ext_on  <= e;
    words   <= w;
  endtask : offer

  // Constant operand: no code word, no fetch
  task automatic kc(input logic [3:0] sr, input logic [1:0] sm, input logic [1:0] lw,
                    input logic [19:0] exp);
    dec(sr, sm, 4'h4, 1'b0, lw);
    chk(src_operand_r, exp, "constant value");
    chk(src_kind_r, OK_CONST, "constant kind");
    chk(fetch_req_r, 1'b0, "constant fetch");
    chk(src_words_r, 2'h0, "constant words");
  endtask : kc

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_consts;
    kc(REG_SR, SM_IND, OW_WORD, K_P4);
    kc(REG_SR, SM_AUTO, OW_WORD, K_P8);
    kc(REG_CG3, SM_REG, OW_WORD, K_0);
    kc(REG_CG3, SM_IDX, OW_WORD, K_P1);
    kc(REG_CG3, SM_IND, OW_BYTE, K_P2);
    kc(REG_CG3, SM_AUTO, OW_BYTE, K_M1_B);
    kc(REG_CG3, SM_AUTO, OW_WORD, K_M1_W);
    kc(REG_CG3, SM_AUTO, OW_A20, K_M1_A);
    chk(width_r, OW_A20, "width code");
  endtask : t_consts

  task automatic t_writes;
    wr(4'h5, OW_A20, 20'habcde, 1'b0);
    chk(regs[5], 20'habcde, "address-word write");
    wr(4'h5, OW_BYTE, 20'habcde, 1'b0);
    chk(regs[5], 20'h000de, "byte write");
    wr(4'h5, OW_WORD, 20'habcde, 1'b0);
    chk(regs[5], 20'h0bcde, "word write");
    wr(4'h5, OW_BYTE, 20'h12380, 1'b1);
    chk(regs[5], 20'hfff80, "sign extend");
    wr(REG_CG3, OW_A20, 20'h12345, 1'b0);
    chk(regs[3], 20'h00000, "constant register written");
    wr(4'h7, OW_A20, 20'habcde, 1'b0);
    dec(4'h7, SM_REG, 4'h8, 1'b0, OW_BYTE);
    chk(src_operand_r, 20'h000de, "byte read");
    chk(src_kind_r, OK_REG, "register kind");
    dec(4'h7, SM_REG, 4'h8, 1'b0, OW_WORD);
    chk(src_operand_r, 20'h0bcde, "word read");
    dec(4'h7, SM_REG, 4'h8, 1'b0, OW_A20);
    chk(src_operand_r, 20'habcde, "address-word read");
    chk(regs[7], 20'habcde, "source kept");
    wr(REG_SR, OW_WORD, 20'h01234, 1'b0);
    dec(REG_SR, SM_REG, 4'h8, 1'b0, OW_WORD);
    chk(src_operand_r, 20'h01234, "status register read");
  endtask : t_writes

  task automatic t_addr;
    logic [19:0] p;
    logic [1:0]  lw [3];
    logic [19:0] inc [3];
    lw  = '{OW_BYTE, OW_WORD, OW_A20};
    inc = '{INC_B, INC_W, INC_A};
    wr(4'h6, OW_A20, 20'h10000, 1'b0);
    wr(REG_PC, OW_A20, 20'h40000, 1'b0);
    offer(1'b1, {4'h1, 4'h0, 16'h2345, 16'h0004});
    dec(4'h6, SM_IDX, 4'h6, 1'b1, OW_WORD);
    chk(src_addr_r, 20'h22345, "indexed with extension");
    chk(src_kind_r, OK_MEM, "memory kind");
    chk(dst_addr_r, 20'h10004, "destination indexed");
    chk(dst_is_mem_r, 1'b1, "destination memory");
    dec(REG_SR, SM_IDX, 4'h4, 1'b0, OW_WORD);
    chk(src_addr_r, 20'h12345, "absolute address");
    dec(REG_PC, SM_IDX, 4'h4, 1'b0, OW_WORD);
    chk(src_addr_r, 20'h52345, "symbolic address");
    offer(1'b0, {4'h0, 4'h0, 16'h8000, 16'h0000});
    dec(4'h6, SM_IDX, 4'h4, 1'b0, OW_WORD);
    chk(src_addr_r, 20'h08000, "negative index");
    @(posedge clock);
    present <= 1'b0;
    dec(4'h6, SM_IND, 4'h4, 1'b0, OW_WORD);
    chk(src_addr_r, 20'h10000, "indirect address");
    repeat (2) @(posedge clock);
    chk(regs[6], 20'h10000, "indirect pointer kept");
    p = 20'h10000;
    for (int i = 0; i < 3; i++) begin
      dec(4'h6, SM_AUTO, 4'h4, 1'b0, lw[i]);
      chk(src_addr_r, p, "autoincrement address");
      p = p + inc[i];
      repeat (2) @(posedge clock);
      chk(regs[6], p, "autoincrement step");
    end
    dec(REG_PC, SM_AUTO, 4'h4, 1'b0, OW_WORD);
    chk(fetch_req_r, 1'b1, "immediate fetch");
    chk(src_words_r, 2'h1, "immediate words");
    repeat (2) @(posedge clock);
    chk(regs[0], 20'h40002, "program counter step");
    dec(REG_PC, SM_AUTO, 4'h4, 1'b0, OW_BYTE);
    repeat (2) @(posedge clock);
    chk(regs[0], 20'h40004, "byte immediate step");
  endtask : t_addr

  // Watchdog: a hang ends in the same report
  initial begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    conclude();
  end

  initial begin
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    #1;
    chk(width_r, 2'b10, "reset width");
    chk(src_operand_r, 20'h0, "reset operand");
    chk(regs[5], 20'h0, "reset register");
    t_consts();
    t_writes();
    t_addr();
    conclude();
  end
endmodule : tb_top
